// ===== hdl/ddr_init_pkg.sv
// Functional notes
// - Type bits sdram_type_on, double_rate_on, second_gen_select set, mobile clear select DDR2.
// - Type bits sdram_type_on, mobile_select, double_rate_on set, second_gen clear select mDDR.
// - Start initialization after either reset release or a write of the config register.
// - Load mode register and extended register 1; for DDR2 also load extended registers 2 and 3 with zero.
// - Finish the DDR2 sequence with two auto-refreshes and the mobile one with one, then idle with all banks precharged.
// - Reset-started sequences begin at once and flush the queued commands and data.
// - Config-write-started sequences keep the queue and wait for pending accesses to drain.
// - DDR2 mode load: CAS latency on bits 6:4, sequential burst, burst of eight.
// - DDR2 mode load: write-recovery code on bits 11:9, zero on bits 12, 8, 7.
// - DDR2 extended load 1: bits 10 and 2 high, bit 6 low.
// - DDR2 extended load 1: drive strength bit 0 on bit 1, other bits zero.
// - Mobile mode load: bits 11:7 zero, CAS latency on 6:4, sequential, burst of eight.
// - Mobile extended load 1: drive strength on bits 6:5, zero on 11:7 and 4:3.
// - Mobile extended load 1: partial refresh select on bits 2:0.
// - Module reset clears state and registers; soft reset clears only the state.
// - Partial refresh codes: 0 all, 1 banks 0-1, 2 bank 0, 5 half, 6 quarter.
package ddr_init_pkg;
    localparam logic [7:0] CFG_OFS = 8'h00;
    localparam logic [7:0] CFG2_OFS = 8'h04;
    localparam logic [7:0] TIM_OFS = 8'h08;
    localparam logic [7:0] TIM2_OFS = 8'h0c;
    localparam logic [7:0] RFC_OFS = 8'h10;
    localparam logic [7:0] STAT_OFS = 8'h14;
    // Config register field positions.
    localparam int PAGE_LSB = 0;
    localparam int BANK_LSB = 4;
    localparam int CL_LSB = 9;
    localparam int DRV_LSB = 12;
    localparam int TIMEN_BIT = 15;
    localparam int TYPE_BIT = 16;
    localparam int DDR_BIT = 17;
    localparam int GEN2_BIT = 20;
    localparam int UNLOCK_BIT = 23;
    localparam int MOB_BIT = 25;
    localparam int WR_LSB = 0;
    localparam int PARTIAL_REFRESH_SELECT_LSB = 0;
    localparam logic [2:0] CL_RST = 3'h3;
    localparam logic [2:0] WR_RST = 3'h3;
    localparam logic [15:0] RATE_RST = 16'h0400;
    localparam logic [2:0] BURST8 = 3'h3;
    localparam logic [2:0] DDR2_LAST = 3'h7;
    localparam logic [2:0] MDDR_LAST = 3'h5;
    localparam logic [3:0] GAP_TICKS = 4'h2;
    // Power-up stable-clock wait before the first command.
    localparam int POWERUP_NS = 200000;
    localparam int CLK_NS = 8;
    localparam int POWERUP_CYC = (POWERUP_NS + CLK_NS - 1) / CLK_NS;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_DRAIN = 3'b001,
        ST_POWERUP = 3'b010,
        ST_ISSUE = 3'b011,
        ST_HOLD = 3'b100,
        ST_GAP = 3'b101,
        ST_DONE = 3'b110
    } seq_state_t;
    typedef struct packed {
        logic        cke;
        logic        cs_n;
        logic        ras_n;
        logic        cas_n;
        logic        we_n;
        logic [1:0]  ba;
        logic [12:0] addr;
    } mem_cmd_t;
    localparam mem_cmd_t CMD_NOP = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 2'b00, 13'h0000};
endpackage

// ===== hdl/ddr_init_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
module ddr_init_sequencer
    import ddr_init_pkg::*;
#(
    parameter int POWERUP_CYCLES = POWERUP_CYC
) (
    input  wire logic        core_clk,
    input  wire logic        arst_n,
    input  wire logic        soft_state_reset_n,
    input  wire logic        memory_ref_clock,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    input  wire logic        queue_busy,
    output logic             queue_flush,
    output logic             access_open,
    output mem_cmd_t         mem_cmd
);
    // Configuration registers, cleared only by the module reset.
    logic [2:0]  page_size_q;
    logic [2:0]  bank_count_q;
    logic [2:0]  cas_latency_q;
    logic [1:0]  drive_strength_q;
    logic        tim_en_q;
    logic        boot_unlock_q;
    logic        sdram_type_on_q;
    logic        double_rate_on_q;
    logic        second_gen_q;
    logic        mobile_select_q;
    logic [2:0]  partial_refresh_select_q;
    logic [31:0] timing_q;
    logic [31:0] timing2_q;
    logic [15:0] refresh_rate_q;

    // Sequencer state; state, step, request and done are visible through the status word.
    seq_state_t  state_q;
    logic [2:0]  step_q;
    logic [3:0]  gap_q;
    logic [31:0] wait_q;
    logic        from_reset_q;
    logic        init_req_q;
    logic        done_q;
    mem_cmd_t    cmd_q;
    logic [31:0] rdata_q;

    // Synchronisers for the soft reset and the reference clock.
    // Only the second soft reset flop and the second and third reference flops feed any logic.
    logic        soft_s1_q;
    logic        soft_s2_q;
    logic        ref_s1_q;
    logic        ref_s2_q;
    logic        ref_s3_q;

    // Decoded helpers.
    logic        ref_tick;
    logic        is_ddr2;
    logic        is_mddr;
    logic        cfg_wr;
    logic [2:0]  last_step;
    logic [12:0] mr_val;
    logic [12:0] emr1_val;

    // Builds one memory command from its three strobes, bank and address.
    // Chip select stays low; NOP is all strobes high.
    function automatic mem_cmd_t make_cmd(input logic [2:0] rcw, input logic [1:0] ba,
                                          input logic [12:0] addr);
        mem_cmd_t c;
        c = CMD_NOP;
        c.ras_n = rcw[2];
        c.cas_n = rcw[1];
        c.we_n = rcw[0];
        c.ba = ba;
        c.addr = addr;
        return c;
    endfunction

    // Type decode from the four select bits.
    // Both flows need sdram_type_on and double_rate_on.
    assign is_ddr2 = sdram_type_on_q & double_rate_on_q & second_gen_q & ~mobile_select_q;
    assign is_mddr = sdram_type_on_q & double_rate_on_q & mobile_select_q & ~second_gen_q;
    // Any other mix selects neither flow at power-up; config-write starts fall to the DDR2 steps.
    assign last_step = is_mddr ? MDDR_LAST : DDR2_LAST;
    assign cfg_wr = reg_wr && (reg_addr == CFG_OFS);

    // Mode and extended mode words; a value the field cannot hold passes unchecked.
    // Write recovery is kept in cycles; the code is one less.
    always_comb begin
        if (is_mddr) begin
            mr_val = {5'h00, 1'b0, cas_latency_q, 1'b0, BURST8};
            emr1_val = {6'h00, drive_strength_q, 2'b00, partial_refresh_select_q};
        end else begin
            mr_val = {1'b0, timing_q[WR_LSB +: 3] - 3'h1, 2'b00, cas_latency_q, 1'b0, BURST8};
            emr1_val = {2'b00, 1'b1, 3'h0, 1'b0, 3'h0, 1'b1, drive_strength_q[0], 1'b0};
        end
    end

    // Two-flop catch of the soft reset level from the power controller.
    // Its reset value is low, so a module reset also restarts power-up.
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            soft_s1_q <= 1'b0;
            soft_s2_q <= 1'b0;
        end else begin
            soft_s1_q <= soft_state_reset_n;
            soft_s2_q <= soft_s1_q;
        end
    end

    // The reference clock is sampled; only the second and third flops feed the edge finder.
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            ref_s1_q <= 1'b0;
            ref_s2_q <= 1'b0;
            ref_s3_q <= 1'b0;
        end else begin
            ref_s1_q <= memory_ref_clock;
            ref_s2_q <= ref_s1_q;
            ref_s3_q <= ref_s2_q;
        end
    end
    // Rising reference edge, about two core cycles late.
    assign ref_tick = ref_s2_q & ~ref_s3_q;

    // Config register; the type bits move only while the boot fields are unlocked.
    // One write cannot unlock and change the type at once.
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            page_size_q <= 3'h0;
            bank_count_q <= 3'h0;
            cas_latency_q <= CL_RST;
            drive_strength_q <= 2'h0;
            tim_en_q <= 1'b0;
            boot_unlock_q <= 1'b0;
            sdram_type_on_q <= 1'b1;
            double_rate_on_q <= 1'b1;
            second_gen_q <= 1'b1;
            mobile_select_q <= 1'b0;
        end else if (cfg_wr) begin
            page_size_q <= reg_wdata[PAGE_LSB +: 3];
            bank_count_q <= reg_wdata[BANK_LSB +: 3];
            cas_latency_q <= reg_wdata[CL_LSB +: 3];
            drive_strength_q <= reg_wdata[DRV_LSB +: 2];
            tim_en_q <= reg_wdata[TIMEN_BIT];
            boot_unlock_q <= reg_wdata[UNLOCK_BIT];
            if (boot_unlock_q) begin
                sdram_type_on_q <= reg_wdata[TYPE_BIT];
                double_rate_on_q <= reg_wdata[DDR_BIT];
                second_gen_q <= reg_wdata[GEN2_BIT];
                mobile_select_q <= reg_wdata[MOB_BIT];
            end
        end
    end

    // Config2 and refresh rate are always writable; timing words need the enable.
    // Locked timing writes are dropped without a flag.
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            partial_refresh_select_q <= 3'h0;
            timing_q <= {29'h0, WR_RST};
            timing2_q <= 32'h0000_0000;
            refresh_rate_q <= RATE_RST;
        end else if (reg_wr) begin
            if (reg_addr == CFG2_OFS) begin
                partial_refresh_select_q <= reg_wdata[PARTIAL_REFRESH_SELECT_LSB +: 3];
            end
            if (reg_addr == TIM_OFS && tim_en_q) begin
                timing_q <= reg_wdata;
            end
            if (reg_addr == TIM2_OFS && tim_en_q) begin
                timing2_q <= reg_wdata;
            end
            if (reg_addr == RFC_OFS) begin
                refresh_rate_q <= reg_wdata[15:0];
            end
        end
    end

    // Read data stand in the cycle after the strobe only; unmapped reads return zero.
    // Clearing between reads keeps stale words off the bus.
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            rdata_q <= 32'h0000_0000;
        end else if (reg_rd) begin
            case (reg_addr)
                CFG_OFS: begin
                    rdata_q <= ({29'h0, page_size_q} << PAGE_LSB)
                             | ({29'h0, bank_count_q} << BANK_LSB)
                             | ({29'h0, cas_latency_q} << CL_LSB)
                             | ({30'h0, drive_strength_q} << DRV_LSB)
                             | ({31'h0, tim_en_q} << TIMEN_BIT)
                             | ({31'h0, sdram_type_on_q} << TYPE_BIT)
                             | ({31'h0, double_rate_on_q} << DDR_BIT)
                             | ({31'h0, second_gen_q} << GEN2_BIT)
                             | ({31'h0, boot_unlock_q} << UNLOCK_BIT)
                             | ({31'h0, mobile_select_q} << MOB_BIT);
                end
                CFG2_OFS: rdata_q <= {29'h0, partial_refresh_select_q};
                TIM_OFS: rdata_q <= timing_q;
                TIM2_OFS: rdata_q <= timing2_q;
                RFC_OFS: rdata_q <= {16'h0, refresh_rate_q};
                STAT_OFS: rdata_q <= {24'h0, done_q, init_req_q, state_q, step_q};
                default: rdata_q <= 32'h0000_0000;
            endcase
        end else begin
            rdata_q <= 32'h0000_0000;
        end
    end
    assign reg_rdata = rdata_q;


    // A config write during a running sequence is remembered and served after it.
    // The set wins over the clear in the same cycle.
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            init_req_q <= 1'b0;
        end else if (cfg_wr) begin
            init_req_q <= 1'b1;
        end else if (state_q == ST_DRAIN || state_q == ST_IDLE || state_q == ST_DONE) begin
            init_req_q <= 1'b0;
        end
    end

    // Main sequencer. Either reset parks it in power-up; commands go out on reference edges.
    // The soft reset acts two cycles late, through its synchroniser.
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_q <= ST_POWERUP;
            step_q <= 3'h0;
            gap_q <= 4'h0;
            wait_q <= 32'h0;
            from_reset_q <= 1'b1;
            done_q <= 1'b0;
        end else if (!soft_s2_q) begin
            state_q <= ST_POWERUP;
            step_q <= 3'h0;
            wait_q <= 32'h0;
            from_reset_q <= 1'b1;
            done_q <= 1'b0;
        end else begin
            case (state_q)
                ST_IDLE, ST_DONE: begin
                    if (init_req_q) begin
                        state_q <= ST_DRAIN;
                        done_q <= 1'b0;
                    end
                end
                ST_DRAIN: begin
                    // Queued work is kept and must finish before the memory is touched.
                    if (!queue_busy) begin
                        state_q <= ST_ISSUE;
                        step_q <= 3'h0;
                        from_reset_q <= 1'b0;
                    end
                end
                ST_POWERUP: begin
                    // Unknown type codes park the block with no command.
                    if (!(is_ddr2 || is_mddr)) begin
                        state_q <= ST_IDLE;
                    end else if (wait_q >= POWERUP_CYCLES - 1) begin
                        state_q <= ST_ISSUE;
                        step_q <= 3'h0;
                    end else begin
                        wait_q <= wait_q + 32'h1;
                    end
                end
                ST_ISSUE: begin
                    if (ref_tick) begin
                        state_q <= ST_HOLD;
                    end
                end
                ST_HOLD: begin
                    if (ref_tick) begin
                        state_q <= ST_GAP;
                        gap_q <= GAP_TICKS;
                    end
                end
                ST_GAP: begin
                    if (ref_tick) begin
                        // NOPs between commands give the memory its recovery time.
                        if (gap_q > 4'h1) begin
                            gap_q <= gap_q - 4'h1;
                        end else if (step_q == last_step) begin
                            state_q <= ST_DONE;
                            done_q <= 1'b1;
                            from_reset_q <= 1'b0;
                        end else begin
                            state_q <= ST_ISSUE;
                            step_q <= step_q + 3'h1;
                        end
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // Command drive: the chosen command stands for one reference period, NOP otherwise.
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            cmd_q <= CMD_NOP;
            cmd_q.cke <= 1'b0;
        end else if (!soft_s2_q) begin
            // Drop clock enable with the state, so no half command is seen.
            cmd_q <= CMD_NOP;
            cmd_q.cke <= 1'b0;
        end else if (state_q == ST_POWERUP) begin
            cmd_q <= CMD_NOP;
            cmd_q.cke <= 1'b0;
        end else if (state_q == ST_ISSUE && ref_tick) begin
            if (is_mddr) begin
                case (step_q)
                    3'h0: cmd_q <= make_cmd(3'b010, 2'b00, 13'h0400);
                    3'h1, 3'h2: cmd_q <= make_cmd(3'b001, 2'b00, 13'h0000);
                    3'h3: cmd_q <= make_cmd(3'b000, 2'b00, mr_val);
                    3'h4: cmd_q <= make_cmd(3'b000, 2'b10, emr1_val);
                    default: cmd_q <= make_cmd(3'b001, 2'b00, 13'h0000);
                endcase
            end else begin
                case (step_q)
                    3'h0, 3'h5: cmd_q <= make_cmd(3'b010, 2'b00, 13'h0400);
                    3'h1: cmd_q <= make_cmd(3'b000, 2'b10, 13'h0000);
                    3'h2: cmd_q <= make_cmd(3'b000, 2'b11, 13'h0000);
                    3'h3: cmd_q <= make_cmd(3'b000, 2'b01, emr1_val);
                    3'h4: cmd_q <= make_cmd(3'b000, 2'b00, mr_val);
                    default: cmd_q <= make_cmd(3'b001, 2'b00, 13'h0000);
                endcase
            end
        end else if (state_q == ST_GAP) begin
            cmd_q <= CMD_NOP;
        end
    end
    assign mem_cmd = cmd_q;

    // Queue flush is a level during reset-started power-up; access opens only when done.
    // A waiting restart keeps access closed even when done.
    assign queue_flush = (state_q == ST_POWERUP) && from_reset_q;
    assign access_open = done_q && !init_req_q;
endmodule
`default_nettype wire

// ===== dv/ddr_init_sequencer_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module ddr_init_sequencer_asserts
    import ddr_init_pkg::*;
#(
    parameter int POWERUP_CYCLES = POWERUP_CYC
) (
    input wire logic        core_clk,
    input wire logic        arst_n,
    input wire logic        soft_state_reset_n,
    input wire logic        memory_ref_clock,
    input wire logic [7:0]  reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic        queue_busy,
    input wire logic        queue_flush,
    input wire logic        access_open,
    input wire mem_cmd_t    mem_cmd
);
    logic [2:0] op;
    logic [4:0] soft_hist_q;
    // Command code from the three strobe lines.
    assign op = {mem_cmd.ras_n, mem_cmd.cas_n, mem_cmd.we_n};
    // Recent soft reset samples, since the synchroniser delays its effect a few cycles.
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            soft_hist_q <= 5'h00;
        end else begin
            soft_hist_q <= {soft_hist_q[3:0], !soft_state_reset_n};
        end
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    a_flush_from_reset:
        assert property ($rose(queue_flush) |-> |soft_hist_q) else $error("flush without reset");
    a_flush_keeps_closed:
        assert property (queue_flush |-> !access_open) else $error("open during flush");
    a_cfg_write_closes:
        assert property (reg_wr && reg_addr == CFG_OFS |=> !access_open)
        else $error("access stays open after config write");
    a_load_while_closed:
        assert property (op == 3'b000 |-> !access_open) else $error("mode load while open");
    a_powerup_quiet:
        assert property (queue_flush |-> !mem_cmd.cke && op == 3'b111)
        else $error("command during power-up");
    a_mode_fixed_bits:
        assert property (op == 3'b000 && mem_cmd.ba == 2'b00 |->
            mem_cmd.addr[12] == 1'b0 && mem_cmd.addr[8:7] == 2'b00 && mem_cmd.addr[3:0] == 4'h3)
        else $error("mode load fixed bits wrong");
    a_ext_one_fixed:
        assert property (op == 3'b000 && mem_cmd.ba == 2'b01 |->
            {mem_cmd.addr[12:2], mem_cmd.addr[0]} == 12'h202)
        else $error("extended load 1 fixed bits wrong");
    a_ext_three_zero:
        assert property (op == 3'b000 && mem_cmd.ba == 2'b11 |-> mem_cmd.addr == 13'h0000)
        else $error("extended load 3 not zero");
    a_cmd_hold:
        assert property (op != 3'b111 && $past(op) == 3'b111 |=> $stable(mem_cmd) [*8])
        else $error("command not held");
    c_ext_three: cover property (op == 3'b000 && mem_cmd.ba == 2'b11);
    c_flush: cover property ($rose(queue_flush));
    c_open: cover property ($rose(access_open));
endmodule
bind ddr_init_sequencer ddr_init_sequencer_asserts #(.POWERUP_CYCLES(POWERUP_CYCLES)) u_asserts (
    .core_clk(core_clk), .arst_n(arst_n), .soft_state_reset_n(soft_state_reset_n),
    .memory_ref_clock(memory_ref_clock), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .queue_busy(queue_busy),
    .queue_flush(queue_flush), .access_open(access_open), .mem_cmd(mem_cmd));
`default_nettype wire

// ===== dv/sdram_model.sv
`timescale 1ns/1ps
`default_nettype none
module sdram_model
    import ddr_init_pkg::*;
(
    input wire logic     core_clk,
    input wire logic     arst_n,
    input wire mem_cmd_t mem_cmd
);
    mem_cmd_t    log_q[$];
    logic [12:0] mode_q [4];
    logic        banks_idle_q = 1'b0;
    logic [2:0]  op_last_q = 3'b111;
    // A command counts once, when it leaves NOP; the controller holds it for a while.
    always @(posedge core_clk) begin
        op_last_q <= {mem_cmd.ras_n, mem_cmd.cas_n, mem_cmd.we_n};
        if (arst_n && mem_cmd.cke && op_last_q == 3'b111 &&
            {mem_cmd.ras_n, mem_cmd.cas_n, mem_cmd.we_n} != 3'b111) begin
            log_q.push_back(mem_cmd);
            if ({mem_cmd.ras_n, mem_cmd.cas_n, mem_cmd.we_n} == 3'b000) begin
                mode_q[mem_cmd.ba] <= mem_cmd.addr;
            end
            if ({mem_cmd.ras_n, mem_cmd.cas_n, mem_cmd.we_n} == 3'b010) begin
                banks_idle_q <= mem_cmd.addr[10];
            end
        end
    end
endmodule
`default_nettype wire

// ===== dv/ddr_init_sequencer_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module ddr_init_sequencer_tb_top
    import ddr_init_pkg::*;
;
    logic        core_clk = 1'b0;
    logic        arst_n = 1'b0;
    logic        soft_state_reset_n = 1'b1;
    logic        memory_ref_clock = 1'b0;
    logic [7:0]  reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic        queue_busy = 1'b0;
    logic [31:0] reg_rdata;
    logic        queue_flush;
    logic        access_open;
    mem_cmd_t    mem_cmd;
    logic [31:0] rd;
    int          n_mismatch = 0;
    int          compares = 0;
    int          cyc = 0;
    int          n0;
    ddr_init_sequencer #(.POWERUP_CYCLES(20)) u_dut (
        .core_clk(core_clk), .arst_n(arst_n), .soft_state_reset_n(soft_state_reset_n),
        .memory_ref_clock(memory_ref_clock), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .queue_busy(queue_busy),
        .queue_flush(queue_flush), .access_open(access_open), .mem_cmd(mem_cmd));
    sdram_model u_mem (.core_clk(core_clk), .arst_n(arst_n), .mem_cmd(mem_cmd));
    // Core clock at 125 MHz.
    always #4 core_clk = ~core_clk;
    // Reference clock at 160 ns, offset so its edges never meet the core edges.
    initial begin
        #3;
        forever #80 memory_ref_clock = ~memory_ref_clock;
    end
    // A hung wait ends the run here rather than in the simulator's own limit.
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 40000) begin
            n_mismatch++;
            report_and_stop();
        end
    end
    task automatic report_and_stop();
        if (n_mismatch == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(logic [7:0] a, logic [31:0] d);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask
    // Read data stands only in the cycle after the strobe, so it is taken just past that edge.
    task automatic rdreg(logic [7:0] a);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 rd = reg_rdata;
    endtask
    task automatic wait_open();
        int i;
        i = 0;
        @(posedge core_clk);
        while (access_open !== 1'b1 && i < 4000) begin
            @(posedge core_clk);
            i++;
        end
        check("access_open", {31'h0, access_open}, 32'h1);
    endtask
    // Looks back from the newest command the memory has seen.
    task automatic chk_cmd(int back, logic [2:0] op, logic [1:0] ba, logic [12:0] a);
        mem_cmd_t c;
        c = u_mem.log_q[u_mem.log_q.size() - back];
        check("command", {29'h0, c.ras_n, c.cas_n, c.we_n}, {29'h0, op});
        if (op == 3'b000) check("load", {17'h0, c.ba, c.addr}, {17'h0, ba, a});
        if (op == 3'b010) check("precharge all", {31'h0, c.addr[10]}, 32'h1);
    endtask
    function automatic logic [31:0] cfg(bit mob, logic [2:0] cl, logic [1:0] drv, bit ten, bit unl);
        logic [31:0] v;
        v = 32'h0;
        v[CL_LSB +: 3] = cl;
        v[DRV_LSB +: 2] = drv;
        v[TIMEN_BIT] = ten;
        v[UNLOCK_BIT] = unl;
        v[TYPE_BIT] = 1'b1;
        v[DDR_BIT] = 1'b1;
        v[GEN2_BIT] = !mob;
        v[MOB_BIT] = mob;
        return v;
    endfunction
    // Unlock, configure, program timing, relock, then set the refresh rate.
    task automatic prog(bit mob, logic [2:0] cl, logic [1:0] drv, logic [2:0] wrc, logic [2:0] partial_refresh_select);
        wr(CFG_OFS, cfg(mob, cl, drv, 1'b0, 1'b1));
        wr(CFG_OFS, cfg(mob, cl, drv, 1'b1, 1'b0));
        if (mob) wr(CFG2_OFS, {29'h0, partial_refresh_select});
        wr(TIM_OFS, {29'h0, wrc});
        wr(TIM2_OFS, 32'h0);
        wr(CFG_OFS, cfg(mob, cl, drv, 1'b0, 1'b0));
        wr(RFC_OFS, 32'h0123);
        wait_open();
    endtask
    task automatic t_after_reset();
        wait_open();
        chk_cmd(8, 3'b010, 2'b00, 13'h0);
        chk_cmd(7, 3'b000, 2'b10, 13'h0);
        chk_cmd(6, 3'b000, 2'b11, 13'h0);
        chk_cmd(5, 3'b000, 2'b01, 13'h0404);
        chk_cmd(4, 3'b000, 2'b00, 13'h0433);
        chk_cmd(1, 3'b001, 2'b00, 13'h0);
        check("banks idle", {31'h0, u_mem.banks_idle_q}, 32'h1);
        rdreg(8'h20);
        check("unmapped", rd, 32'h0);
        wr(TIM_OFS, 32'h5);
        rdreg(TIM_OFS);
        check("locked timing", rd, 32'h3);
    endtask
    task automatic t_ddr2_prog();
        prog(1'b0, 3'h5, 2'h1, 3'h4, 3'h0);
        chk_cmd(5, 3'b000, 2'b01, 13'h0406);
        chk_cmd(4, 3'b000, 2'b00, 13'h0653);
        rdreg(RFC_OFS);
        check("refresh rate", rd, 32'h0123);
    endtask
    // A config write must wait for pending accesses and must not flush them.
    task automatic t_drain();
        n0 = u_mem.log_q.size();
        queue_busy <= 1'b1;
        wr(CFG_OFS, cfg(1'b0, 3'h5, 2'h1, 1'b0, 1'b0));
        repeat (200) @(posedge core_clk);
        check("commands while busy", 32'(u_mem.log_q.size()), 32'(n0));
        check("flush on write", {31'h0, queue_flush}, 32'h0);
        queue_busy <= 1'b0;
        wait_open();
        check("sequence after drain", 32'(u_mem.log_q.size()), 32'(n0 + 8));
    endtask
    task automatic t_mddr();
        prog(1'b1, 3'h2, 2'h2, 3'h3, 3'h5);
        chk_cmd(6, 3'b010, 2'b00, 13'h0);
        chk_cmd(3, 3'b000, 2'b00, 13'h0023);
        chk_cmd(2, 3'b000, 2'b10, 13'h0045);
        chk_cmd(1, 3'b001, 2'b00, 13'h0);
        for (int i = 0; i < 4; i++) begin
            wr(CFG2_OFS, (i == 3) ? 32'h6 : 32'(i));
            wr(CFG_OFS, cfg(1'b1, 3'h2, 2'h2, 1'b0, 1'b0));
            wait_open();
            chk_cmd(2, 3'b000, 2'b10, (i == 3) ? 13'h0046 : 13'h0040 + 13'(i));
        end
    endtask
    // Soft reset restarts from power-up but keeps the configuration.
    task automatic t_soft();
        soft_state_reset_n <= 1'b0;
        repeat (3) @(posedge core_clk);
        soft_state_reset_n <= 1'b1;
        repeat (3) @(posedge core_clk);
        #1 check("flush after soft reset", {31'h0, queue_flush}, 32'h1);
        rdreg(CFG_OFS);
        check("kept cas latency", {29'h0, rd[CL_LSB +: 3]}, 32'h2);
        wait_open();
        chk_cmd(2, 3'b000, 2'b10, 13'h0046);
    endtask
    task automatic t_hard();
        arst_n <= 1'b0;
        repeat (2) @(posedge core_clk);
        arst_n <= 1'b1;
        rdreg(CFG_OFS);
        check("cleared cas latency", {29'h0, rd[CL_LSB +: 3]}, 32'h3);
        rdreg(RFC_OFS);
        check("cleared refresh rate", rd, 32'h0400);
        wait_open();
        chk_cmd(4, 3'b000, 2'b00, 13'h0433);
    endtask
    // Main sequence: hold reset for five cycles, then each scenario in turn.
    initial begin
        repeat (5) @(posedge core_clk);
        arst_n <= 1'b1;
        t_after_reset();
        t_ddr2_prog();
        t_drain();
        t_mddr();
        t_soft();
        t_hard();
        report_and_stop();
    end
endmodule
`default_nettype wire
